// ===== verilog/mpr_pkg.sv
// Package holding constants and carrier types of the mode page and reservation command decoder.
package mpr_pkg;
  // Operation codes of the handled commands.
  localparam logic [7:0] OP_SENSE10  = 8'h5A;
  localparam logic [7:0] OP_SELECT6  = 8'h15;
  localparam logic [7:0] OP_SELECT10 = 8'h55;
  localparam logic [7:0] OP_PR_QUERY = 8'h5E;
  // Command block byte positions and field positions.
  localparam int CDB_LEN      = 10;
  localparam int B_FLAGS      = 1;
  localparam int B_LEN6       = 4;
  localparam int B_LEN_MSB    = 7;
  localparam int B_LEN_LSB    = 8;
  localparam int BIT_SAVE     = 0;
  localparam int SA_MSB       = 4;
  // Parameter list layout.
  localparam logic [15:0] HDR_LEN  = 16'h0004;
  localparam logic [7:0]  BDESC_LEN = 8'h08;
  // Query service actions.
  localparam logic [4:0] SA_READ_KEYS = 5'h00;
  localparam logic [4:0] SA_READ_RESV = 5'h01;
  // Status, sense key and additional sense codes.
  localparam logic [7:0] ST_GOOD     = 8'h00;
  localparam logic [7:0] ST_CHECK    = 8'h02;
  localparam logic [7:0] ST_CONFLICT = 8'h18;
  localparam logic [3:0] SK_NONE     = 4'h0;
  localparam logic [3:0] SK_ILLEGAL  = 4'h5;
  localparam logic [3:0] SK_UNIT_ATT = 4'h6;
  localparam logic [7:0] ASC_NONE    = 8'h00;
  localparam logic [7:0] ASC_BAD_CDB = 8'h24;
  localparam logic [7:0] ASC_PARM_LIST = 8'h26;
  localparam logic [7:0] ASC_PARM_CHG  = 8'h2A;
  // Mode page store sizes, initiator count and generation reset value.
  localparam int NUM_PAGES   = 64;
  localparam int PAGE_AW     = 6;
  localparam int STORE_AW    = 10;
  localparam int STORE_DEPTH = 1024;
  localparam int NUM_INIT    = 8;
  localparam logic [31:0] GEN_RESET = 32'h0000_0000;

  // Completion of one command.
  typedef struct packed {
    logic [7:0] status;
    logic [3:0] sense_key;
    logic [7:0] asc;
  } mpr_done_s;

  // Byte handed to the host side.
  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } mpr_byte_s;
endpackage

// ===== verilog/mpr_store.sv
// Single port page store with registered read data.
`timescale 1ns/1ps
module mpr_store
  import mpr_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                we,
  input  wire logic [STORE_AW-1:0] addr,
  input  wire logic [7:0]          wdata,
  output logic      [7:0]          rdata
);
  logic [7:0] mem [STORE_DEPTH];

  // Write and registered read share the address; read returns the old byte.
  always_ff @(posedge clock) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ===== verilog/mpr_cmd.sv
// Command decoder for parameter report, parameter update and reservation query commands.
`timescale 1ns/1ps
module mpr_cmd
  import mpr_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 cmd_valid,
  input  wire logic [79:0]          cmd_cdb,
  input  wire logic [2:0]           cmd_init,
  input  wire logic                 legacy_resv,
  input  wire logic                 gen_bump,
  input  wire logic [7:0]           page_len_ref,
  output logic      [PAGE_AW-1:0]   page_len_sel,
  input  wire logic                 out_valid,
  input  wire logic [7:0]           out_data,
  output logic                      out_ready,
  output mpr_byte_s                 in_byte,
  input  wire logic                 in_ready,
  output logic                      busy,
  output mpr_done_s                 done_info,
  output logic                      done,
  output logic                      save_req,
  output logic [STORE_AW-1:0]       save_addr,
  output logic [NUM_INIT-1:0]       unit_att,
  input  wire logic [NUM_INIT-1:0]  unit_att_clr,
  output logic [31:0]               generation
);
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_RECV  = 3'b001,
    S_SEND  = 3'b010,
    S_DONE  = 3'b011
  } mpr_state_e;

  mpr_state_e  state;
  logic        rst_q1;
  logic        rst_q2;
  logic [15:0] count;
  logic [15:0] limit;
  logic        save_bit;
  logic        is_select;
  logic        bad_len;
  logic        changed;
  logic [7:0]  hdr_bd_len;
  logic [15:0] page_end;
  logic [1:0]  page_phase;
  logic [STORE_AW-1:0] wr_addr;
  logic [STORE_AW-1:0] rd_addr;
  logic [7:0]  store_q;
  logic        store_we;
  logic [2:0]  sender;

  // Byte i of the command block; byte 0 is the opcode in the top bits.
  function automatic logic [7:0] cdb_byte(input logic [79:0] cdb, input int idx);
    cdb_byte = cdb[79-8*idx -: 8];
  endfunction

  // The same length field is read by the ten-byte update and by report and query; the six-byte update reads byte 4.
  function automatic logic [15:0] len16(input logic [79:0] cdb);
    len16 = {cdb_byte(cdb, B_LEN_MSB), cdb_byte(cdb, B_LEN_LSB)};
  endfunction

  // Reset is released through two flops so that every stage leaves reset together.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  wire logic [7:0] opcode = cdb_byte(cmd_cdb, 0);
  wire logic [7:0] flags  = cdb_byte(cmd_cdb, B_FLAGS);
  wire logic [4:0] svc    = flags[SA_MSB:0];

  // Page store shared by every initiator, one copy only.
  // common page set
  mpr_store u_store (
    .clock (clock),
    .we    (store_we),
    .addr  (state == S_RECV ? wr_addr : rd_addr),
    .wdata (out_data),
    .rdata (store_q)
  );

  // Accepted page data bytes are written straight into the live store unless a length field was bad.
  // Page code and length bytes stay out, or they would land on another page's bytes.
  // volatile apply
  assign store_we  = (state == S_RECV) && out_valid && out_ready && !bad_len &&
                     (count >= HDR_LEN + {8'h00, hdr_bd_len}) &&
                     (page_phase == 2'd2) && (count != page_end);
  assign out_ready = (state == S_RECV);
  assign busy      = (state != S_IDLE);

  // Main command sequencer.
  always_ff @(posedge clock or negedge rst_q2) begin
    if (!rst_q2) begin
      state     <= S_IDLE;
      count     <= 16'h0000;
      limit     <= 16'h0000;
      save_bit  <= 1'b0;
      is_select <= 1'b0;
      sender    <= 3'h0;
      done_info <= '0;
    end else begin
      case (state)
        S_IDLE: begin
          count <= 16'h0000;
          if (cmd_valid) begin
            sender    <= cmd_init;
            save_bit  <= flags[BIT_SAVE];
            is_select <= 1'b0;
            done_info <= '{status: ST_GOOD, sense_key: SK_NONE, asc: ASC_NONE};
            case (opcode)
              OP_SELECT6: begin
                limit     <= {8'h00, cdb_byte(cmd_cdb, B_LEN6)};
                is_select <= 1'b1;
                state     <= (cdb_byte(cmd_cdb, B_LEN6) == 8'h00) ? S_DONE : S_RECV;
              end
              OP_SELECT10: begin
                limit     <= len16(cmd_cdb);
                is_select <= 1'b1;
                state     <= (len16(cmd_cdb) == 16'h0000) ? S_DONE : S_RECV;
              end
              OP_SENSE10: begin
                limit <= len16(cmd_cdb);
                state <= (len16(cmd_cdb) == 16'h0000) ? S_DONE : S_SEND;
              end
              OP_PR_QUERY: begin
                limit <= len16(cmd_cdb);
                if (legacy_resv) begin
                  done_info <= '{status: ST_CONFLICT, sense_key: SK_NONE, asc: ASC_NONE};
                  state     <= S_DONE;
                end else if (svc != SA_READ_KEYS && svc != SA_READ_RESV) begin
                  done_info <= '{status: ST_CHECK, sense_key: SK_ILLEGAL,
                                 asc: ASC_BAD_CDB};
                  state     <= S_DONE;
                end else begin
                  state <= (len16(cmd_cdb) == 16'h0000) ? S_DONE : S_SEND;
                end
              end
              default: begin
                done_info <= '{status: ST_CHECK, sense_key: SK_ILLEGAL, asc: ASC_BAD_CDB};
                state     <= S_DONE;
              end
            endcase
          end
        end
        S_RECV: begin
          if (out_valid) begin
            count <= count + 16'h0001;
            if (count + 16'h0001 == limit) begin
              state <= S_DONE;
              if (bad_len || (page_phase != 2'd0 && count + 16'h0001 != page_end)) begin
                done_info <= '{status: ST_CHECK, sense_key: SK_ILLEGAL,
                               asc: ASC_PARM_LIST};
              end
            end
          end
        end
        S_SEND: begin
          if (in_byte.valid && in_ready) begin
            count <= count + 16'h0001;
            if (count + 16'h0001 == limit) begin
              state <= S_DONE;
            end
          end
        end
        S_DONE: begin
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Parse the parameter list: header, optional descriptor, then page headers.
  // list structure
  always_ff @(posedge clock or negedge rst_q2) begin
    if (!rst_q2) begin
      hdr_bd_len <= 8'h00;
      page_phase <= 2'd0;
      page_end   <= 16'h0000;
      bad_len    <= 1'b0;
      wr_addr    <= '0;
      changed    <= 1'b0;
    end else if (state == S_IDLE) begin
      page_phase <= 2'd0;
      bad_len    <= 1'b0;
      changed    <= 1'b0;
      hdr_bd_len <= 8'h00;
    end else if (state == S_RECV && out_valid) begin
      // Header byte 3 gives descriptor length; only zero or one descriptor is legal.
      if (count == HDR_LEN - 16'h0001) begin
        hdr_bd_len <= out_data;
        page_end   <= HDR_LEN + {8'h00, out_data};
        if (out_data != 8'h00 && out_data != BDESC_LEN) begin
          bad_len <= 1'b1;
        end
      end else if (count >= HDR_LEN && count == page_end) begin
        page_phase <= 2'd1;
        wr_addr    <= {out_data[PAGE_AW-1:0], 4'h0};
      end else if (page_phase == 2'd1) begin
        page_phase <= 2'd2;
        page_end   <= count + 16'h0001 + {8'h00, out_data};
        if (out_data != page_len_ref) begin
          bad_len <= 1'b1;
        end
      end else if (page_phase == 2'd2) begin
        wr_addr <= wr_addr + STORE_AW'(1);
        changed <= 1'b1;
      end
    end
  end

  assign page_len_sel = wr_addr[STORE_AW-1:4];

  // Report data comes from the store, one byte per accepted cycle.
  always_ff @(posedge clock or negedge rst_q2) begin
    if (!rst_q2) begin
      rd_addr <= '0;
      in_byte <= '0;
    end else if (state == S_SEND) begin
      // A byte stands until taken; valid drops as soon as the last one is taken.
      if (!in_byte.valid || in_ready) begin
        in_byte.valid <= !(in_byte.valid && count + 16'h0001 == limit);
        in_byte.data  <= store_q;
        rd_addr       <= rd_addr + STORE_AW'(1);
      end
    end else begin
      rd_addr <= '0;
      in_byte <= '0;
    end
  end

  // Completion pulse and save request at the end of a good update.
  // saved to disk
  always_ff @(posedge clock or negedge rst_q2) begin
    if (!rst_q2) begin
      done      <= 1'b0;
      save_req  <= 1'b0;
      save_addr <= '0;
    end else begin
      done      <= (state == S_DONE);
      save_req  <= (state == S_DONE) && is_select && save_bit &&
                   (done_info.status == ST_GOOD) && changed;
      save_addr <= wr_addr;
    end
  end

  // Unit attention for every other initiator; a new set wins over a clear.
  // parameters changed
  always_ff @(posedge clock or negedge rst_q2) begin
    if (!rst_q2) begin
      unit_att <= '0;
    end else begin
      for (int i = 0; i < NUM_INIT; i++) begin
        if (state == S_DONE && is_select && changed && done_info.status == ST_GOOD &&
            i[2:0] != sender) begin
          unit_att[i] <= 1'b1;
        end else if (unit_att_clr[i]) begin
          unit_att[i] <= 1'b0;
        end
      end
    end
  end

  // Registration generation, bumped by the reservation-out logic outside.
  // generation reset
  always_ff @(posedge clock or negedge rst_q2) begin
    if (!rst_q2) begin
      generation <= GEN_RESET;
    end else if (gen_bump) begin
      generation <= generation + 32'h0000_0001;
    end
  end

  // A conflict answer must follow a query taken under a legacy reservation.
  sequence legacy_query_s;
    state == S_IDLE && cmd_valid && opcode == OP_PR_QUERY && legacy_resv;
  endsequence

  legacy_conflict_a: assert property (@(posedge clock) disable iff (!rst_q2)
    legacy_query_s |=> ##1 (done && done_info.status == ST_CONFLICT))
    else $error("Query under legacy reservation did not conflict.");

  bad_action_a: assert property (@(posedge clock) disable iff (!rst_q2)
    (state == S_IDLE && cmd_valid && opcode == OP_PR_QUERY && !legacy_resv &&
     svc > SA_READ_RESV) |=> ##1 (done && done_info.asc == ASC_BAD_CDB))
    else $error("Reserved service action was not refused.");

  zero_len_a: assert property (@(posedge clock) disable iff (!rst_q2)
    (state == S_IDLE && cmd_valid && opcode == OP_SELECT6 &&
     cdb_byte(cmd_cdb, B_LEN6) == 8'h00) |=> (state == S_DONE) ##1
    (done && done_info.status == ST_GOOD))
    else $error("Zero length update did not finish cleanly.");

  no_overrun_a: assert property (@(posedge clock) disable iff (!rst_q2)
    state == S_SEND |-> count < limit)
    else $error("Returned data passed allocation length.");

  sender_attention_a: assert property (@(posedge clock) disable iff (!rst_q2)
    (state == S_DONE && is_select && changed && done_info.status == ST_GOOD)
    |=> (unit_att[sender] == $past(unit_att[sender]) || !unit_att[sender]))
    else $error("Sender received its own unit attention.");

  len_mismatch_a: assert property (@(posedge clock) disable iff (!rst_q2)
    (state == S_RECV && bad_len && out_valid && count + 16'h0001 == limit)
    |=> ##1 (done && done_info.sense_key == SK_ILLEGAL))
    else $error("Page length mismatch not reported.");

  no_save_a: assert property (@(posedge clock) disable iff (!rst_q2)
    (state == S_DONE && !save_bit) |=> !save_req)
    else $error("Volatile update requested a save.");

  gen_hold_a: assert property (@(posedge clock) disable iff (!rst_q2)
    !gen_bump |=> generation == $past(generation))
    else $error("Generation changed without a bump.");
endmodule

// ===== testbench/mpr_host.sv
// Initiator host adapter model that feeds data-out bytes and takes data-in bytes.
`timescale 1ns/1ps
module mpr_host
  import mpr_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      out_ready,
  output logic           out_valid,
  output logic     [7:0] out_data,
  input  wire mpr_byte_s in_byte,
  output logic           in_ready
);
  logic [7:0] tx_q[$];
  logic       slow;
  int         rx_cnt;

  // Quiet start: nothing offered, data-in accepted at once.
  initial begin
    out_valid = 1'b0;
    out_data  = 8'h00;
    in_ready  = 1'b1;
    slow      = 1'b0;
    rx_cnt    = 0;
  end

  // whole list in order, page lengths as the bench queued them.
  always @(posedge clock) begin
    if (out_valid && out_ready) begin
      void'(tx_q.pop_front());
    end
    if (in_byte.valid && in_ready) begin
      rx_cnt++;
    end
  end

  // Signals move only at the falling edge; an idle data line toggles so stale bytes never look fresh.
  always @(negedge clock) begin
    in_ready <= slow ? ~in_ready : 1'b1;
    if (tx_q.size() != 0) begin
      out_valid <= 1'b1;
      out_data  <= tx_q[0];
    end else begin
      out_valid <= 1'b0;
      out_data  <= ~out_data;
    end
  end
endmodule

// ===== testbench/mpr_cmd_tb.sv
// Self-checking bench for the mode page and reservation command decoder.
`timescale 1ns/1ps
module mpr_cmd_tb;
  import mpr_pkg::*;
  localparam logic [7:0] PG_LEN = 8'h0E;
  logic                clock, rst_n, cmd_valid, legacy_resv, gen_bump;
  logic                out_valid, out_ready, in_ready, busy, done, save_req;
  logic [79:0]         cmd_cdb;
  logic [2:0]          cmd_init;
  logic [7:0]          out_data;
  logic [NUM_INIT-1:0] unit_att, unit_att_clr;
  logic [31:0]         generation;
  mpr_byte_s           in_byte;
  mpr_done_s           done_info;
  logic [PAGE_AW-1:0]  save_page, len_sel;
  logic [STORE_AW-1:0] save_addr;
  logic [7:0]          len_ref;
  int                  failures, checked, cycles, saves;

  // Far side page length table: only page 01 exists, PG_LEN bytes long.
  assign len_ref = (len_sel == 6'h01) ? PG_LEN : 8'h00;

  mpr_cmd uut (
    .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_cdb(cmd_cdb),
    .cmd_init(cmd_init), .legacy_resv(legacy_resv), .gen_bump(gen_bump),
    .page_len_ref(len_ref), .page_len_sel(len_sel), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready), .in_byte(in_byte),
    .in_ready(in_ready), .busy(busy), .done_info(done_info), .done(done),
    .save_req(save_req), .save_addr(save_addr), .unit_att(unit_att),
    .unit_att_clr(unit_att_clr), .generation(generation)
  );
  mpr_host host (
    .clock(clock), .out_ready(out_ready), .out_valid(out_valid),
    .out_data(out_data), .in_byte(in_byte), .in_ready(in_ready)
  );

  // Free-running 25 MHz clock.
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Cycle ceiling cuts a hang short; save pulses are counted here as well.
  always @(posedge clock) begin
    cycles++;
    if (save_req === 1'b1) begin
      saves++;
      save_page = save_addr[STORE_AW-1:4];
    end
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [79:0] cdb(input logic [7:0] op, b1, b4, b7, b8);
    return {op, b1, 16'h0000, b4, 16'h0000, b7, b8, 8'h00};
  endfunction

  // Issues one command and counts falling edges from the take until done.
  task automatic run(input logic [79:0] c, input logic [2:0] who, output int lat);
    @(negedge clock);
    cmd_cdb   = c;
    cmd_init  = who;
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    chk("busy after take", 1, busy);
    lat = 1;
    while (done !== 1'b1 && lat < 2000) begin
      @(negedge clock);
      lat++;
    end
  endtask

  // Sends an update list: header, optional descriptor, one page of length plen.
  task automatic t_list(input logic [7:0] op, input logic sp, input logic [2:0] who,
                        input logic desc, input logic [7:0] plen);
    int         lat, s0;
    logic [7:0] n;
    n = 8'd6 + (desc ? 8'd8 : 8'd0) + plen;
    unit_att_clr = '1;
    host.tx_q = '{8'h00, 8'h00, 8'h00, desc ? 8'h08 : 8'h00};
    for (int i = 0; i < (desc ? 8 : 0); i++) host.tx_q.push_back(8'h00);
    host.tx_q.push_back(8'h01);
    host.tx_q.push_back(plen);
    for (int i = 0; i < plen; i++) host.tx_q.push_back(8'h40 + 8'(i) + 8'(who));
    @(negedge clock);
    unit_att_clr = '0;
    s0 = saves;
    if (op == OP_SELECT6) run(cdb(op, {7'h00, sp}, n, 8'h00, 8'h00), who, lat);
    else run(cdb(op, {3'h0, 1'b1, 3'h0, sp}, 8'h00, 8'h00, n), who, lat);
    repeat (4) @(negedge clock);
    if (plen == PG_LEN) begin
      chk("list status", {ST_GOOD, SK_NONE, ASC_NONE}, done_info);
      chk("list bytes left", 0, host.tx_q.size());
      chk("unit attention", 8'(~(8'h01 << who)), unit_att);
      chk("save pulses", sp, saves - s0);
      if (sp) chk("save page", 1, save_page);
    end else begin
      chk("bad length status", {ST_CHECK, SK_ILLEGAL, ASC_PARM_LIST}, done_info);
      host.tx_q.delete();
    end
  endtask

  // Query commands with short allocation, plus refusal cases.
  task automatic t_query();
    int lat;
    legacy_resv = 1'b1;
    run(cdb(OP_PR_QUERY, 8'h00, 8'h00, 8'h00, 8'h08), 3'd1, lat);
    chk("conflict latency", 2, lat);
    chk("conflict status", {ST_CONFLICT, SK_NONE, ASC_NONE}, done_info);
    legacy_resv = 1'b0;
    for (int sa = 0; sa < 32; sa++) begin
      host.rx_cnt = 0;
      host.slow = (sa == 1);
      run(cdb(OP_PR_QUERY, 8'(sa), 8'h00, 8'h00, 8'h03), 3'd4, lat);
      if (sa < 2) begin
        chk("query status", {ST_GOOD, SK_NONE, ASC_NONE}, done_info);
        chk("query bytes", 3, host.rx_cnt);
      end else begin
        chk("bad action", {ST_CHECK, SK_ILLEGAL, ASC_BAD_CDB}, done_info);
      end
    end
    host.slow = 1'b0;
    host.rx_cnt = 0;
    run(cdb(8'hC3, 8'h00, 8'h00, 8'h00, 8'h00), 3'd0, lat);
    chk("unknown opcode", {ST_CHECK, SK_ILLEGAL, ASC_BAD_CDB}, done_info);
    chk("unknown bytes", 0, host.rx_cnt);
  endtask

  initial begin
    int lat;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_cdb = '0;
    cmd_init = '0;
    legacy_resv = 1'b0;
    gen_bump = 1'b0;
    unit_att_clr = '0;
    failures = 0;
    checked = 0;
    cycles = 0;
    saves = 0;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    chk("generation at reset", 0, generation);
    chk("attention at reset", 0, unit_att);
    run(cdb(OP_SELECT6, 8'h00, 8'h00, 8'h00, 8'h00), 3'd3, lat);
    chk("zero list latency", 2, lat);
    chk("zero list status", {ST_GOOD, SK_NONE, ASC_NONE}, done_info);
    host.rx_cnt = 0;
    // Current store values fetched before any update, reply cut at three bytes.
    run(cdb(OP_SENSE10, 8'h00, 8'h00, 8'h00, 8'h03), 3'd5, lat);
    chk("report status", {ST_GOOD, SK_NONE, ASC_NONE}, done_info);
    chk("report bytes", 3, host.rx_cnt);
    t_list(OP_SELECT6, 1'b0, 3'd0, 1'b1, PG_LEN);
    t_list(OP_SELECT10, 1'b1, 3'd2, 1'b0, PG_LEN);
    t_list(OP_SELECT6, 1'b0, 3'd6, 1'b0, 8'h0C);
    t_query();
    // Counter steps, then a reset in mid-run must clear it again.
    repeat (3) begin
      @(negedge clock);
      gen_bump = 1'b1;
      @(negedge clock);
      gen_bump = 1'b0;
    end
    @(negedge clock);
    chk("generation count", 3, generation);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    chk("generation cleared", 0, generation);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    print_verdict();
  end
endmodule
